// file: hats_hall_model.sv
`timescale 1ns/1ps
// Paired plate channels whose harmonic mean always equals four times the ramp level
module hats_hall_model
   import hats_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        run,
   input  wire logic                        magnet,
   input  wire logic                        slow,
   output logic [NUM_PLATES-1:0]            meas_valid,
   output logic [NUM_PLATES-1:0][CNT_W-1:0] chan_north,
   output logic [NUM_PLATES-1:0][CNT_W-1:0] chan_south
);
   logic [CNT_W-1:0] lvl_q;
   logic             tick_q;
   always_ff @(posedge clk) begin
      tick_q <= run & ~reset & ~tick_q;
      if (reset || !run) begin
         lvl_q <= 16'h0001;
      end else if (meas_valid[0]) begin
         lvl_q <= lvl_q + 16'h0001;
      end
   end
   // Slow mode gives a fresh count every other cycle
   always_comb begin
      meas_valid = {NUM_PLATES{run && (!slow || tick_q)}};
      for (int p = 0; p < NUM_PLATES; p++) begin
         chan_north[p] = magnet ? 16'(3 * lvl_q) : 16'(4 * lvl_q);
         chan_south[p] = magnet ? 16'(6 * lvl_q) : 16'(4 * lvl_q);
      end
   end
endmodule

// file: hats_pkg.sv
package hats_pkg;
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned CNT_W       = 16;
   localparam int unsigned COARSE_W    = 4;
   localparam int unsigned FINE_W      = 5;
   localparam int unsigned COMP_W      = 10;
   localparam int unsigned NUM_PLATES  = 2;
   localparam int unsigned PLATE_W     = 1;

   // Register offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h01;
   localparam logic [7:0] OFS_BASE0    = 8'h02;
   localparam logic [7:0] OFS_TARGET0  = 8'h03;
   localparam logic [7:0] OFS_RESULT0  = 8'h04;
   localparam logic [7:0] OFS_REF0     = 8'h05;
   localparam logic [7:0] OFS_STRIDE   = 8'h04;
   localparam logic [7:0] OFS_ADDR     = 8'h0c;

   // Control fields
   localparam int unsigned CTRL_RETUNE_BIT = 0;
   localparam int unsigned CTRL_EVENT_BIT  = 1;
   localparam int unsigned CTRL_PEND_BIT   = 2;
   localparam int unsigned CTRL_SLOW_BIT   = 3;
   localparam logic [3:0]  CTRL_RESET      = 4'h0;
   localparam logic [CNT_W-1:0] BASE_RESET   = 16'h0200;
   localparam logic [CNT_W-1:0] TARGET_RESET = 16'h0400;

   // Bus address option
   localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h44;
   localparam logic [6:0] BUS_ADDR_ALT     = 7'h45;

   // Times in microseconds
   localparam int unsigned T_INIT_US      = 6000;
   localparam int unsigned T_TEST_US      = 5000;
   localparam int unsigned T_COMMS_US     = 2000;
   localparam int unsigned T_STAB_US      = 70000;
   localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
   localparam int unsigned T_INIT_CYC     = T_INIT_US * CYC_PER_US;
   localparam int unsigned T_TEST_CYC     = T_TEST_US * CYC_PER_US;
   localparam int unsigned T_COMMS_CYC    = T_COMMS_US * CYC_PER_US;
   localparam int unsigned T_STAB_CYC     = T_STAB_US * CYC_PER_US;
   localparam int unsigned TMR_W          = 24;

   typedef enum logic [2:0] {
      HATS_INIT, HATS_TEST, HATS_COMM1, HATS_TUNE, HATS_COMM2, HATS_STAB, HATS_SENSE
   } hats_phase_e;
endpackage

// file: hats_plate_tuner.sv
`timescale 1ns/1ps
// Per-plate tuner: multiplier search at zero compensation, then compensation ramp
module hats_plate_tuner
   import hats_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                start,
   input  wire logic                ref_ok,
   input  wire logic [CNT_W-1:0]    ref_count,
   input  wire logic [CNT_W-1:0]    base_val,
   input  wire logic [CNT_W-1:0]    target_val,
   output logic      [COARSE_W-1:0] coarse,
   output logic      [FINE_W-1:0]   fine,
   output logic      [COMP_W-1:0]   comp,
   output logic                     done
);
   typedef enum logic [1:0] {HATS_T_IDLE, HATS_T_MULT, HATS_T_COMP, HATS_T_DONE} hats_tune_e;
   hats_tune_e          st_q, st_d;
   logic [COARSE_W-1:0] coarse_q, coarse_d;
   logic [FINE_W-1:0]   fine_q, fine_d;
   logic [COMP_W-1:0]   comp_q, comp_d;

   always_comb begin
      st_d     = st_q;
      coarse_d = coarse_q;
      fine_d   = fine_q;
      comp_d   = comp_q;
      unique case (st_q)
         HATS_T_IDLE: begin
            if (start) begin
               coarse_d = '0;
               fine_d   = '0;
               comp_d   = '0;
               st_d     = HATS_T_MULT;
            end
         end
         HATS_T_MULT: begin
            // Larger base keeps raising multipliers longer
            if (ref_ok) begin
               if (ref_count >= base_val) begin
                  st_d = HATS_T_COMP;
               end else if (fine_q != '1) begin
                  fine_d = fine_q + 1'b1;
               end else if (coarse_q != '1) begin
                  coarse_d = coarse_q + 1'b1;
                  fine_d   = '0;
               end else begin
                  st_d = HATS_T_COMP;
               end
            end
         end
         HATS_T_COMP: begin
            // Higher target keeps raising compensation longer
            if (ref_ok) begin
               if (ref_count >= target_val || comp_q == '1) begin
                  st_d = HATS_T_DONE;
               end else begin
                  comp_d = comp_q + 1'b1;
               end
            end
         end
         HATS_T_DONE: begin
            if (start) begin
               st_d     = HATS_T_MULT;
               coarse_d = '0;
               fine_d   = '0;
               comp_d   = '0;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q     <= HATS_T_IDLE;
         coarse_q <= '0;
         fine_q   <= '0;
         comp_q   <= '0;
      end else begin
         st_q     <= st_d;
         coarse_q <= coarse_d;
         fine_q   <= fine_d;
         comp_q   <= comp_d;
      end
   end

   assign coarse = coarse_q;
   assign fine   = fine_q;
   assign comp   = comp_q;
   assign done   = (st_q == HATS_T_DONE);
endmodule

// file: hats_ref_calc.sv
`timescale 1ns/1ps
// Reference of a plate: p*q/(2*(p+q)) == 1/(2*(1/p+1/q))
module hats_ref_calc
   import hats_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [CNT_W-1:0] chan_north,
   input  wire logic [CNT_W-1:0] chan_south,
   output logic      [CNT_W-1:0] ref_count
);
   logic [2*CNT_W-1:0] prod;
   logic [CNT_W+1:0]   den;
   logic [2*CNT_W-1:0] quo;
   logic [CNT_W-1:0]   ref_d;
   logic [CNT_W-1:0]   ref_q;

   always_comb begin
      prod = chan_north * chan_south;
      den  = {{1'b0, chan_north} + {1'b0, chan_south}, 1'b0};
      if (den == '0) begin
         quo = '0;
      end else begin
         quo = prod / {{(CNT_W-2){1'b0}}, den};
      end
      ref_d = (quo[2*CNT_W-1:CNT_W] != '0) ? '1 : quo[CNT_W-1:0];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ref_q <= '0;
      end else begin
         ref_q <= ref_d;
      end
   end

   assign ref_count = ref_q;
endmodule

// file: hats_seq_props.sv
`timescale 1ns/1ps
module hats_seq_props
   import hats_pkg::*;
#(
   parameter int unsigned COMMS_CYC = T_COMMS_CYC
)
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        addr_option,
   input wire logic        bus_stop,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic [6:0]  bus_addr,
   input wire logic        comm_window,
   input wire logic        tuning_active,
   input wire logic        sensing
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [15:0] win_q;
   logic [15:0] win_d;
   always_comb begin
      win_d = comm_window ? win_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge clk) begin
      win_q <= reset ? 16'h0000 : win_d;
   end
   chk_addr_take: assert property (
      $fell(reset) |=> bus_addr == ($past(addr_option) ? BUS_ADDR_ALT : BUS_ADDR_DEFAULT))
      else $error("bus address differs from option");
   chk_addr_hold: assert property (!$past(reset) |=> $stable(bus_addr))
      else $error("bus address changed");
   chk_modes_excl: assert property (
      !(sensing && (tuning_active || comm_window)) && !(tuning_active && comm_window))
      else $error("two phases at once");
   chk_quiet_start: assert property (
      $fell(reset) |-> (!comm_window && !tuning_active && !sensing) [*8])
      else $error("activity during init");
   chk_tune_entry: assert property (
      $rose(tuning_active) |-> $past(comm_window) || $past(sensing))
      else $error("tuning entered out of order");
   chk_settle_gap: assert property (
      $fell(tuning_active) && !comm_window |-> !sensing [*8])
      else $error("sensing without settling");
   chk_stop_ends: assert property (bus_stop && comm_window |-> ##[1:2] !comm_window)
      else $error("stop did not end window");
   chk_win_bound: assert property (win_q <= 2 * COMMS_CYC + 1)
      else $error("window too long");
   chk_sense_hold: assert property (sensing && !reg_wr |=> sensing)
      else $error("sensing left without retune");
   chk_sense_retune: assert property (
      sensing && reg_wr && reg_addr == OFS_CTRL && reg_wdata[0] |-> ##[1:3] tuning_active)
      else $error("retune not started");
endmodule
bind hats_sequencer hats_seq_props #(.COMMS_CYC(COMMS_CYC)) i_hats_seq_props (
   .clk, .reset, .addr_option, .bus_stop, .reg_addr, .reg_wdata, .reg_wr, .bus_addr,
   .comm_window, .tuning_active, .sensing);

// file: hats_sequencer.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Tuning uses two measurement channels per sensing plate.
// - The two channels of a plate are inverted copies, one north and one south.
// - Plate reference is one over twice the sum of reciprocals of the paired counts.
// - The paired reference does not change with a magnet present, so tuning may run near one.
// - Tuning sets coarse, fine and compensation per plate from a base and a target value.
// - First phase holds compensation at zero and raises the multipliers toward the base.
// - A larger base gives larger multipliers and a smaller base smaller ones.
// - Compensation rises only after the multipliers are fixed, until the target is reached.
// - A higher target gives more compensation and more sensitivity.
// - With event mode and a pending event the window after tuning ends at a stop or 2 ms, doubled at 8 MHz.
// - The bus address is 44h in the default option and 45h in the alternative one.
module hats_sequencer
   import hats_pkg::*;
#(
   parameter int unsigned INIT_CYC  = T_INIT_CYC,
   parameter int unsigned TEST_CYC  = T_TEST_CYC,
   parameter int unsigned COMMS_CYC = T_COMMS_CYC,
   parameter int unsigned STAB_CYC  = T_STAB_CYC
)
(
   input  wire logic                                clk,
   input  wire logic                                reset,
   input  wire logic                                addr_option,
   input  wire logic                                bus_stop,
   input  wire logic [NUM_PLATES-1:0]               meas_valid,
   input  wire logic [NUM_PLATES-1:0][CNT_W-1:0]    chan_north,
   input  wire logic [NUM_PLATES-1:0][CNT_W-1:0]    chan_south,
   input  wire logic [7:0]                          reg_addr,
   input  wire logic [31:0]                         reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic      [31:0]                         reg_rdata,
   output logic      [6:0]                          bus_addr,
   output logic                                     comm_window,
   output logic                                     tuning_active,
   output logic                                     sensing
);
   import hats_pkg::*;

   // Phase, timer and register-bus state
   hats_phase_e                 ph_q, ph_d;
   logic [TMR_W-1:0]            tmr_q, tmr_d;
   logic [3:0]                  ctrl_q, ctrl_d;
   logic [31:0]                 rdata_q, rdata_d;
   logic [6:0]                  addr_q, addr_d;
   logic                        win_q, win_d;
   logic                        tun_q, tun_d;
   logic                        sen_q, sen_d;
   logic                        opt_caught_q, opt_caught_d;
   logic [NUM_PLATES-1:0][CNT_W-1:0]    base_q, base_d;
   logic [NUM_PLATES-1:0][CNT_W-1:0]    tgt_q, tgt_d;
   // Per-plate reference, tuner inputs and outputs, tuning start
   logic [NUM_PLATES-1:0][CNT_W-1:0]    ref_w;
   logic [NUM_PLATES-1:0][COARSE_W-1:0] coarse_w;
   logic [NUM_PLATES-1:0][FINE_W-1:0]   fine_w;
   logic [NUM_PLATES-1:0][COMP_W-1:0]   comp_w;
   logic [NUM_PLATES-1:0]               done_w;
   logic [NUM_PLATES-1:0]               ok_q;
   logic                                tune_start;
   logic                                retune;

   // Last timer count of a phase, doubled in slow mode
   function automatic logic [TMR_W-1:0] lim(input int unsigned cyc, input logic slow);
      lim = slow ? TMR_W'(2 * cyc - 1) : TMR_W'(cyc - 1);
   endfunction

   // Matches a per-plate register offset and returns the plate index
   function automatic logic plate_hit(input logic [7:0] a, input logic [7:0] ofs,
                                      output logic [PLATE_W-1:0] idx);
      logic hit;
      hit = 1'b0;
      idx = '0;
      for (int p = 0; p < NUM_PLATES; p++) begin
         if (a == 8'(ofs + 8'(p) * OFS_STRIDE)) begin
            hit = 1'b1;
            idx = PLATE_W'(p);
         end
      end
      return hit;
   endfunction

   // Paired channels per plate feed a magnet-independent reference
   for (genvar g = 0; g < NUM_PLATES; g++) begin : g_plate
      hats_ref_calc u_ref (
         .clk        (clk),
         .reset      (reset),
         .chan_north (chan_north[g]),
         .chan_south (chan_south[g]),
         .ref_count  (ref_w[g])
      );
      hats_plate_tuner u_tune (
         .clk        (clk),
         .reset      (reset),
         .start      (tune_start),
         .ref_ok     (ok_q[g]),
         .ref_count  (ref_w[g]),
         .base_val   (base_q[g]),
         .target_val (tgt_q[g]),
         .coarse     (coarse_w[g]),
         .fine       (fine_w[g]),
         .comp       (comp_w[g]),
         .done       (done_w[g])
      );
   end

   // Tuning starts on leaving the first window or on a retune in sensing
   assign retune     = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_RETUNE_BIT];
   assign tune_start = (ph_q == HATS_COMM1 && ph_d == HATS_TUNE) ||
                       (ph_q == HATS_SENSE && retune);

   // Phase sequencer
   always_comb begin
      ph_d  = ph_q;
      tmr_d = tmr_q + 1'b1;
      unique case (ph_q)
         HATS_INIT: begin
            if (tmr_q >= lim(INIT_CYC, 1'b0)) begin
               ph_d  = HATS_TEST;
               tmr_d = '0;
            end
         end
         HATS_TEST: begin
            if (tmr_q >= lim(TEST_CYC, 1'b0)) begin
               ph_d  = HATS_COMM1;
               tmr_d = '0;
            end
         end
         HATS_COMM1: begin
            if (bus_stop || tmr_q >= lim(COMMS_CYC, ctrl_q[CTRL_SLOW_BIT])) begin
               ph_d  = HATS_TUNE;
               tmr_d = '0;
            end
         end
         HATS_TUNE: begin
            tmr_d = '0;
            if (&done_w) begin
               if (ctrl_q[CTRL_EVENT_BIT] && ctrl_q[CTRL_PEND_BIT]) begin
                  ph_d = HATS_COMM2;
               end else begin
                  ph_d = HATS_STAB;
               end
            end
         end
         HATS_COMM2: begin
            if (bus_stop || tmr_q >= lim(COMMS_CYC, ctrl_q[CTRL_SLOW_BIT])) begin
               ph_d  = HATS_STAB;
               tmr_d = '0;
            end
         end
         HATS_STAB: begin
            if (tmr_q >= lim(STAB_CYC, ctrl_q[CTRL_SLOW_BIT])) begin
               ph_d  = HATS_SENSE;
               tmr_d = '0;
            end
         end
         HATS_SENSE: begin
            tmr_d = '0;
            if (retune) begin
               ph_d = HATS_TUNE;
            end
         end
         default: begin
            ph_d  = HATS_INIT;
            tmr_d = '0;
         end
      endcase
   end

   // Phase and timer registers
   always_ff @(posedge clk) begin
      if (reset) begin
         ph_q  <= HATS_INIT;
         tmr_q <= '0;
      end else begin
         ph_q  <= ph_d;
         tmr_q <= tmr_d;
      end
   end

   // Fresh-count flags, one cycle behind the channels
   always_ff @(posedge clk) begin
      if (reset) begin
         ok_q <= '0;
      end else begin
         ok_q <= meas_valid;
      end
   end

   // Address option, caught once after reset
   always_comb begin
      opt_caught_d = 1'b1;
      addr_d       = addr_q;
      // Later option changes are ignored until the next reset
      if (!opt_caught_q) begin
         addr_d = addr_option ? BUS_ADDR_ALT : BUS_ADDR_DEFAULT;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         addr_q       <= BUS_ADDR_DEFAULT;
         opt_caught_q <= 1'b0;
      end else begin
         addr_q       <= addr_d;
         opt_caught_q <= opt_caught_d;
      end
   end

   // Control and per-plate setting registers
   always_comb begin
      logic [PLATE_W-1:0] ix;
      ix     = '0;
      ctrl_d = ctrl_q;
      base_d = base_q;
      tgt_d  = tgt_q;
      if (reg_wr) begin
         if (reg_addr == OFS_CTRL) begin
            // Retune bit is a pulse and is not kept
            ctrl_d = {reg_wdata[CTRL_SLOW_BIT:CTRL_EVENT_BIT], 1'b0};
         end else if (plate_hit(reg_addr, OFS_BASE0, ix)) begin
            base_d[ix] = reg_wdata[CNT_W-1:0];
         end else if (plate_hit(reg_addr, OFS_TARGET0, ix)) begin
            tgt_d[ix] = reg_wdata[CNT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q <= CTRL_RESET;
         base_q <= {NUM_PLATES{BASE_RESET}};
         tgt_q  <= {NUM_PLATES{TARGET_RESET}};
      end else begin
         ctrl_q <= ctrl_d;
         base_q <= base_d;
         tgt_q  <= tgt_d;
      end
   end

   // Read data stands for the cycle after the strobe only
   always_comb begin
      logic [PLATE_W-1:0] ix;
      ix      = '0;
      // Unmapped addresses read as zero
      rdata_d = '0;
      if (reg_rd) begin
         if (reg_addr == OFS_CTRL) begin
            rdata_d = {28'h0, ctrl_q};
         end else if (reg_addr == OFS_STATUS) begin
            // Status: plate done bits and current phase
            rdata_d = {26'h0, done_w, 1'b0, ph_q};
         end else if (reg_addr == OFS_ADDR) begin
            rdata_d = {25'h0, addr_q};
         end else if (plate_hit(reg_addr, OFS_BASE0, ix)) begin
            rdata_d = {16'h0, base_q[ix]};
         end else if (plate_hit(reg_addr, OFS_TARGET0, ix)) begin
            rdata_d = {16'h0, tgt_q[ix]};
         end else if (plate_hit(reg_addr, OFS_RESULT0, ix)) begin
            // Result word: compensation, fine, coarse
            rdata_d = {13'h0, comp_w[ix], fine_w[ix], coarse_w[ix]};
         end else if (plate_hit(reg_addr, OFS_REF0, ix)) begin
            rdata_d = {16'h0, ref_w[ix]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Phase flags follow the next phase so they line up with it
   always_comb begin
      win_d = (ph_d == HATS_COMM1) || (ph_d == HATS_COMM2);
      tun_d = (ph_d == HATS_TUNE);
      sen_d = (ph_d == HATS_SENSE);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         win_q <= 1'b0;
         tun_q <= 1'b0;
         sen_q <= 1'b0;
      end else begin
         win_q <= win_d;
         tun_q <= tun_d;
         sen_q <= sen_d;
      end
   end

   assign reg_rdata     = rdata_q;
   assign bus_addr      = addr_q;
   assign comm_window   = win_q;
   assign tuning_active = tun_q;
   assign sensing       = sen_q;
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
   import hats_pkg::*;
   localparam int unsigned C = 20;
   logic                             clk, reset, addr_option, bus_stop, reg_wr, reg_rd;
   logic                             magnet, slow, rd_d, comm_window, tuning_active, sensing;
   logic [NUM_PLATES-1:0]            meas_valid;
   logic [NUM_PLATES-1:0][CNT_W-1:0] chan_north, chan_south;
   logic [7:0]                       reg_addr;
   logic [6:0]                       bus_addr, ea;
   logic [31:0]                      reg_wdata, reg_rdata, last_rd, ra0, ra1, base0;
   logic [31:0]                      exp_q[$], msk_q[$];
   int                               err_total, tests_run, cyc, win_n, stop_at, lo, hi;
   int                               win_q[$];
   hats_sequencer #(.INIT_CYC(C), .TEST_CYC(C), .COMMS_CYC(C), .STAB_CYC(C)) i_hats_sequencer (
      .clk, .reset, .addr_option, .bus_stop, .meas_valid, .chan_north, .chan_south, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_addr, .comm_window, .tuning_active,
      .sensing);
   hats_hall_model i_hats_hall_model (.clk, .reset, .run(tuning_active), .magnet, .slow,
      .meas_valid, .chan_north, .chan_south);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic stop_test();
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Mask zero captures the word without judging it
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wait_sense();
      repeat (3) @(posedge clk);
      while (sensing !== 1'b1) @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d === 1'b1) begin
         last_rd = reg_rdata;
         check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   // Window lengths, stop pulse and hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         stop_test();
      end
      if (comm_window === 1'b1) begin
         win_n++;
         bus_stop <= (win_n == stop_at);
      end else begin
         if (win_n != 0) win_q.push_back(win_n);
         win_n = 0;
         bus_stop <= 1'b0;
      end
   end
   initial begin
      {reset, addr_option, reg_wr, reg_rd, magnet, slow, bus_stop, rd_d} = 8'h80;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      void'($urandom(39707));
      for (int i = 0; i < 3; i++) begin
         reset <= 1'b1;
         addr_option <= 1'($urandom);
         slow <= (i == 0);
         magnet <= 1'b0;
         stop_at = (i == 1) ? 5 : 0;
         base0 = 32'h100 + ($urandom % 64);
         repeat (10) @(posedge clk);
         reset <= 1'b0;
         win_q.delete();
         @(posedge clk);
         @(posedge clk);
         #1;
         ea = addr_option ? BUS_ADDR_ALT : BUS_ADDR_DEFAULT;
         check(bus_addr, ea);
         wr(OFS_CTRL, {28'h0, i == 0, 1'b1, i != 2, 1'b0});
         wr(OFS_BASE0, base0);
         wr(OFS_TARGET0, base0 + 32'h80);
         wr(OFS_BASE0 + OFS_STRIDE, base0 + 32'h80);
         wr(OFS_TARGET0 + OFS_STRIDE, base0 + 32'h100);
         wait_sense();
         check(win_q.size(), (i == 2) ? 1 : 2);
         lo = (i == 0) ? 2 * C : (i == 1) ? 5 : C;
         hi = (i == 1) ? 8 : lo + 1;
         foreach (win_q[k]) check(win_q[k] >= lo && win_q[k] <= hi, 1);
         wr(OFS_ADDR, 32'h0);
         rd(OFS_ADDR, ea, '1);
         rd(8'hff, 0, '1);
         rd(OFS_STATUS, 32'h36, '1);
         rd(OFS_BASE0 + OFS_STRIDE, base0 + 32'h80, '1);
         if (i == 0) begin
            rd(OFS_REF0, 32'h1, '1);
            rd(OFS_RESULT0, 0, 0);
            ra0 = last_rd;
            rd(OFS_RESULT0 + OFS_STRIDE, 0, 0);
            ra1 = last_rd;
            check({ra1[3:0], ra1[8:4]} > {ra0[3:0], ra0[8:4]}, 1);
            check(ra0[18:9] != 0, 1);
            repeat (50) @(posedge clk);
            rd(OFS_RESULT0, ra0, '1);
            magnet <= 1'b1;
            rd(OFS_REF0 + OFS_STRIDE, 32'h1, '1);
            wr(OFS_CTRL, 32'hf);
            wait_sense();
            rd(OFS_RESULT0, ra0, '1);
            rd(OFS_RESULT0 + OFS_STRIDE, ra1, '1);
            wr(OFS_TARGET0, base0 + 32'h100);
            wr(OFS_CTRL, 32'hf);
            wait_sense();
            rd(OFS_RESULT0, 0, 0);
            check(last_rd[8:0], ra0[8:0]);
            check(last_rd[18:9] > ra0[18:9], 1);
         end
      end
      stop_test();
   end
endmodule
